// ### hw/sfe_cfg.svh
// Constants for the serial flash erase sequencer: opcodes, address layout,
// erase times. Assumes a 40 MHz core clock.
`ifndef SFE_CFG_SVH
`define SFE_CFG_SVH
`define SFE_CLK_PERIOD_NS 25
`define SFE_OP_BLOCK_ERASE 8'h50
`define SFE_OP_SECTOR_ERASE 8'h7C
`define SFE_CE_BYTE0 8'hC7
`define SFE_CE_BYTE1 8'h94
`define SFE_CE_BYTE2 8'h80
`define SFE_CE_BYTE3 8'h9A
`define SFE_BLOCK_LAST 7'h7F
`define SFE_ERASED_BYTE 8'hFF
// Page field lsb inside the 24-bit address for each page size
`define SFE_PAGE_LSB_264 9
`define SFE_PAGE_LSB_256 8
// Erase times in microseconds
`define SFE_BLOCK_ERASE_US 45000
`define SFE_SECTOR_ERASE_MAX_US 5000000
`define SFE_CHIP_ERASE_US 6000000
// Scale by cycles per microsecond first so multi-second counts fit an int
`define SFE_US_TO_CYC(t) ((t) * (1000 / `SFE_CLK_PERIOD_NS))
`endif

// ### hw/sfe_pkg.sv
// Types for the serial flash erase sequencer.
// Assumes sfe_cfg.svh is included by the users for the constants.
package sfe_pkg;
	typedef enum logic [2:0] {
		SFE_IDLE = 3'b000,
		SFE_OPCODE = 3'b001,
		SFE_ADDR = 3'b010,
		SFE_CHIP_SEQ = 3'b011,
		SFE_SWALLOW = 3'b100,
		SFE_BUSY = 3'b101
	} sfe_state_type;
	typedef enum logic [1:0] {
		SFE_KIND_BLOCK = 2'b00,
		SFE_KIND_SECTOR = 2'b01,
		SFE_KIND_CHIP = 2'b10
	} sfe_kind_type;
	// One erase request towards the array
	typedef struct packed {
		logic [1:0] kind;
		logic [3:0] sector;
		logic [6:0] block;
	} sfe_erase_type;
endpackage

// ### hw/sfe_erase_seq.sv
// Erase command decoder and self-timed erase sequencer of a serial flash.
// Assumes SPI mode 0/3 pins from the host, sampled on the 40 MHz core clock;
// the array side takes one erase strobe per sector map, masked by protection and locks for chip erase only.
`timescale 1ns/1ps
`include "sfe_cfg.svh"

// How it works
// - Block erase uses the top seven page bits as block 0 to 127.
// - One sector erase command clears exactly one sector.
// - The sector is picked from the upper page bits alone.
// - Chip select rising after sector erase starts a timed erase.
// - Busy is reported for the whole internal erase.
// - Chip erase needs C7H 94H 80H 9AH in order under one select.
// - Bytes after the chip erase sequence are ignored.
// - Chip select rising after the sequence starts the chip erase.
// - Chip erase skips protected and locked sectors.
// - Write protect raised mid-erase applies only after the erase.
// - Erased locations read back as all ones.
module sfe_erase_seq #(
	parameter int BLOCK_ERASE_CYC = `SFE_US_TO_CYC(`SFE_BLOCK_ERASE_US),
	parameter int SECTOR_ERASE_CYC =
		`SFE_US_TO_CYC(`SFE_SECTOR_ERASE_MAX_US),
	parameter int CHIP_ERASE_CYC = `SFE_US_TO_CYC(`SFE_CHIP_ERASE_US)
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic page_size_256,
	input wire logic wp_n,
	input wire logic sw_protect,
	input wire logic [7:0] protect_map,
	input wire logic [7:0] lock_map,
	output logic busy,
	output logic protect_active,
	output logic erase_strobe,
	output sfe_pkg::sfe_erase_type erase_req,
	output logic [7:0] erase_sector_map,
	output logic [7:0] erase_fill
);
	// The busy counter cannot serve an erase of zero cycles
	if (BLOCK_ERASE_CYC < 1 || SECTOR_ERASE_CYC < 1 ||
		CHIP_ERASE_CYC < 1) begin : g_bad_cycles
		$error("erase cycle counts must be at least one");
	end

	// Two-flop synchronisers for pins
	logic [2:0] cs_s;
	logic [2:0] sck_s;
	logic [1:0] si_s;
	logic [1:0] wp_s;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cs_s <= 3'h7;
			sck_s <= 3'h0;
			si_s <= 2'h0;
			wp_s <= 2'h3;
		end else begin
			cs_s <= {cs_s[1:0], cs_n};
			sck_s <= {sck_s[1:0], sck};
			si_s <= {si_s[0], si};
			wp_s <= {wp_s[0], wp_n};
		end
	end
	wire cs_low = ~cs_s[1];
	wire cs_rise = cs_s[1] & ~cs_s[2];
	wire sck_rise = sck_s[1] & ~sck_s[2] & cs_low;
	wire si_bit = si_s[1];
	wire wp_asserted = ~wp_s[1];

	// Byte assembly
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	wire [7:0] next_byte = {shreg[6:0], si_bit};
	wire byte_done = sck_rise && bit_cnt == 3'h7;

	sfe_pkg::sfe_state_type state;
	logic [1:0] kind;
	logic [1:0] idx;
	logic [23:0] addr;
	logic armed;
	logic [31:0] timer;

	function automatic logic [7:0] ce_byte(input logic [1:0] i);
		case (i)
			2'h0: ce_byte = `SFE_CE_BYTE0;
			2'h1: ce_byte = `SFE_CE_BYTE1;
			2'h2: ce_byte = `SFE_CE_BYTE2;
			default: ce_byte = `SFE_CE_BYTE3;
		endcase
	endfunction

	// Upper seven page bits, aligned per page size
	function automatic logic [6:0] upper_page_bits(input logic [23:0] a,
		input logic bin);
		if (bin)
			upper_page_bits = a[`SFE_PAGE_LSB_256+9 -: 7];
		else
			upper_page_bits = a[`SFE_PAGE_LSB_264+9 -: 7];
	endfunction

	wire [6:0] block_idx = upper_page_bits(addr, page_size_256);
	wire [2:0] top_page_bits = block_idx[6:4];
	// Sector 0 splits into 0a (block 0) and 0b (blocks 1..15)
	wire [3:0] sector_idx = (top_page_bits != 3'h0) ?
		{1'b0, top_page_bits} + 4'h1 :
		(block_idx == 7'h00 ? 4'h0 : 4'h1);
	wire [8:0] sector_mask9 = 9'h001 << sector_idx;

	// Protection latched only between erases
	logic prot_latched;
	wire [8:0] guard9 = {lock_map, lock_map[0]} |
		({protect_map, protect_map[0]} & {9{prot_latched}});
	wire [8:0] chip_map9 = ~guard9;
	wire [7:0] next_map = (kind == sfe_pkg::SFE_KIND_CHIP) ?
		chip_map9[8:1] : (sector_mask9[8:1] | {7'h00, sector_mask9[0]});

	wire [31:0] erase_len = (kind == sfe_pkg::SFE_KIND_CHIP) ?
		CHIP_ERASE_CYC : (kind == sfe_pkg::SFE_KIND_SECTOR) ?
		SECTOR_ERASE_CYC : BLOCK_ERASE_CYC;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bit_cnt <= 3'h0;
			shreg <= 8'h00;
		end else if (!cs_low) begin
			bit_cnt <= 3'h0;
		end else if (sck_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			shreg <= next_byte;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= sfe_pkg::SFE_IDLE;
			kind <= sfe_pkg::SFE_KIND_BLOCK;
			idx <= 2'h0;
			addr <= 24'h000000;
			armed <= 1'b0;
			timer <= 32'h0;
			busy <= 1'b0;
			erase_strobe <= 1'b0;
			erase_req <= '0;
			erase_sector_map <= 8'h00;
			erase_fill <= `SFE_ERASED_BYTE;
		end else begin
			erase_strobe <= 1'b0;
			erase_fill <= `SFE_ERASED_BYTE;
			case (state)
			sfe_pkg::SFE_IDLE: begin
				armed <= 1'b0;
				idx <= 2'h0;
				if (cs_low)
					state <= sfe_pkg::SFE_OPCODE;
			end
			sfe_pkg::SFE_OPCODE: begin
				if (cs_rise)
					state <= sfe_pkg::SFE_IDLE;
				else if (byte_done) begin
					if (next_byte == `SFE_OP_BLOCK_ERASE) begin
						kind <= sfe_pkg::SFE_KIND_BLOCK;
						state <= sfe_pkg::SFE_ADDR;
					end else if (next_byte == `SFE_OP_SECTOR_ERASE) begin
						kind <= sfe_pkg::SFE_KIND_SECTOR;
						state <= sfe_pkg::SFE_ADDR;
					end else if (next_byte == ce_byte(2'h0)) begin
						kind <= sfe_pkg::SFE_KIND_CHIP;
						idx <= 2'h1;
						state <= sfe_pkg::SFE_CHIP_SEQ;
					end else
						state <= sfe_pkg::SFE_SWALLOW;
				end
			end
			sfe_pkg::SFE_ADDR: begin
				if (cs_rise)
					state <= sfe_pkg::SFE_IDLE;
				else if (byte_done) begin
					addr <= {addr[15:0], next_byte};
					idx <= idx + 2'h1;
					if (idx == 2'h2) begin
						armed <= 1'b1;
						state <= sfe_pkg::SFE_SWALLOW;
					end
				end
			end
			sfe_pkg::SFE_CHIP_SEQ: begin
				if (cs_rise)
					state <= sfe_pkg::SFE_IDLE;
				else if (byte_done) begin
					if (next_byte != ce_byte(idx))
						state <= sfe_pkg::SFE_SWALLOW;
					else if (idx == 2'h3) begin
						armed <= 1'b1;
						state <= sfe_pkg::SFE_SWALLOW;
					end
					idx <= idx + 2'h1;
				end
			end
			sfe_pkg::SFE_SWALLOW: begin
				// Trailing bytes change nothing
				if (cs_rise) begin
					if (armed) begin
						state <= sfe_pkg::SFE_BUSY;
						busy <= 1'b1;
						timer <= erase_len;
						erase_strobe <= 1'b1;
						erase_req <= '{kind: kind, sector: sector_idx,
							block: block_idx};
						erase_sector_map <= next_map;
					end else
						state <= sfe_pkg::SFE_IDLE;
				end
			end
			sfe_pkg::SFE_BUSY: begin
				if (timer <= 32'h1) begin
					busy <= 1'b0;
					state <= sfe_pkg::SFE_IDLE;
				end
				timer <= timer - 32'h1;
			end
			default: state <= sfe_pkg::SFE_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prot_latched <= 1'b0;
			protect_active <= 1'b0;
		end else if (!busy) begin
			prot_latched <= wp_asserted | sw_protect;
			protect_active <= wp_asserted | sw_protect;
		end
	end

	chk_busy_after_strobe: assert property (
		@(posedge clock) disable iff (rst)
		erase_strobe |-> busy)
		else $error("busy not raised with erase start");
	chk_prot_hold_busy: assert property (
		@(posedge clock) disable iff (rst)
		busy && $past(busy) |-> $stable(protect_active))
		else $error("protection changed during erase");
	chk_start_on_cs: assert property (
		@(posedge clock) disable iff (rst)
		erase_strobe |-> $past(cs_rise))
		else $error("erase started without select rising");
	chk_fill_ones: assert property (
		@(posedge clock) disable iff (rst)
		erase_fill == 8'hFF)
		else $error("erase fill not all ones");
	chk_one_sector: assert property (
		@(posedge clock) disable iff (rst)
		erase_strobe && erase_req.kind == sfe_pkg::SFE_KIND_SECTOR |->
		$onehot(erase_sector_map))
		else $error("sector erase hit more than one sector");
	chk_chip_guard: assert property (
		@(posedge clock) disable iff (rst)
		erase_strobe && erase_req.kind == sfe_pkg::SFE_KIND_CHIP |->
		(erase_sector_map[7:1] & $past(lock_map[7:1])) == 7'h00)
		else $error("chip erase touched a locked sector");
	chk_block_range: assert property (
		@(posedge clock) disable iff (rst)
		erase_strobe |-> erase_req.block == ($past(page_size_256) ?
		$past(addr[`SFE_PAGE_LSB_256+9 -: 7]) :
		$past(addr[`SFE_PAGE_LSB_264+9 -: 7])))
		else $error("block index not taken from upper page bits");
	chk_sector_pick: assert property (
		@(posedge clock) disable iff (rst)
		erase_strobe && erase_req.block[6:4] != 3'h0 |->
		erase_req.sector == {1'b0, erase_req.block[6:4]} + 4'h1)
		else $error("sector not taken from upper page bits");
	chk_chip_seq: assert property (
		@(posedge clock) disable iff (rst)
		state == sfe_pkg::SFE_CHIP_SEQ && byte_done &&
		next_byte != ce_byte(idx) |=> !armed)
		else $error("wrong chip erase byte armed the erase");
	chk_busy_clears: assert property (
		@(posedge clock) disable iff (rst)
		busy && timer == 32'h1 |=> !busy)
		else $error("busy did not clear at timer end");
	chk_no_restart: assert property (
		@(posedge clock) disable iff (rst)
		busy |=> !erase_strobe)
		else $error("erase restarted while busy");
	chk_tail_ignored: assert property (
		@(posedge clock) disable iff (rst)
		state == sfe_pkg::SFE_SWALLOW && !cs_rise |=>
		state == sfe_pkg::SFE_SWALLOW && $stable(armed))
		else $error("trailing bytes changed the command");

	// Armed command closed by select rising starts the erase one edge later
	sequence seq_armed_close;
		state == sfe_pkg::SFE_SWALLOW && armed && cs_rise;
	endsequence
	sequence seq_erase_start;
		erase_strobe && busy;
	endsequence
	chk_armed_start: assert property (
		@(posedge clock) disable iff (rst)
		seq_armed_close |=> seq_erase_start)
		else $error("armed command did not start an erase");

	// Protection held back during an erase takes hold once busy drops
	sequence seq_erase_end;
		busy ##1 !busy;
	endsequence
	chk_prot_after: assert property (
		@(posedge clock) disable iff (rst)
		seq_erase_end ##0 (wp_asserted || sw_protect) |=> protect_active)
		else $error("protection not applied after the erase");
endmodule

// ### tb/sfe_host.sv
// Host side serial controller model: drives select, clock and data.
// Assumes mode 0 framing; the bench calls xfer once busy has cleared.
`timescale 1ns/1ps
module sfe_host (
	output logic cs_n,
	output logic sck,
	output logic si
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// Sends n bits MSB first; the clock stands low outside frames
	task automatic xfer(input logic [39:0] w, input int n);
		#13 cs_n = 1'b0;
		#200;
		for (int i = n - 1; i >= 0; i--) begin
			si = w[i];
			#100 sck = 1'b1;
			#100 sck = 1'b0;
		end
		si = ~si;
		#200 cs_n = 1'b1;
	endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the erase sequencer driven by the host model.
// Assumes sfe_cfg.svh on the include path; erase counts are set to 20.
`timescale 1ns/1ps
`include "sfe_cfg.svh"
module tb_top;
	typedef struct {
		logic [1:0] k;
		logic [6:0] v;
		logic [7:0] m;
	} sfe_note_type;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cs_n;
	logic sck;
	logic si;
	logic page_size_256 = 1'b0;
	logic wp_n = 1'b1;
	logic sw_protect = 1'b0;
	logic [7:0] protect_map = 8'h00;
	logic [7:0] lock_map = 8'h00;
	logic busy;
	logic protect_active;
	logic erase_strobe;
	sfe_pkg::sfe_erase_type erase_req;
	logic [7:0] erase_sector_map;
	logic [7:0] erase_fill;
	sfe_note_type notes[$];
	sfe_note_type mon_note;
	int n_fail = 0;
	int total_checks = 0;
	always #12.5 clock = ~clock;
	sfe_host u_sfe_host (.cs_n(cs_n), .sck(sck), .si(si));
	sfe_erase_seq #(.BLOCK_ERASE_CYC(20), .SECTOR_ERASE_CYC(20),
		.CHIP_ERASE_CYC(20)) u_sfe_erase_seq (.clock(clock), .rst(rst),
		.cs_n(cs_n), .sck(sck), .si(si), .page_size_256(page_size_256),
		.wp_n(wp_n), .sw_protect(sw_protect), .protect_map(protect_map),
		.lock_map(lock_map), .busy(busy), .protect_active(protect_active),
		.erase_strobe(erase_strobe), .erase_req(erase_req),
		.erase_sector_map(erase_sector_map), .erase_fill(erase_fill));
	task automatic fail(input string msg);
		$display("BAD %0t %s", $time, msg);
		n_fail++;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		total_checks++;
		if (got !== exp) fail(what);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Random don't care bits around the block index
	function automatic logic [23:0] place(input logic [6:0] b);
		int lsb;
		lsb = page_size_256 ? `SFE_PAGE_LSB_256 + 3 : `SFE_PAGE_LSB_264 + 3;
		return (24'($urandom) & ~(24'h00007F << lsb)) | (24'(b) << lsb);
	endfunction
	function automatic sfe_note_type sec_note(input logic [6:0] b);
		logic [3:0] s;
		s = (b == 7'h00) ? 4'h0 : (b < 7'h10) ? 4'h1 : {1'b0, b[6:4]} + 4'h1;
		sec_note.k = sfe_pkg::SFE_KIND_SECTOR;
		sec_note.v = {3'h0, s};
		sec_note.m = 8'h01 << ((s < 4'h2) ? 4'h0 : s - 4'h1);
	endfunction
	task automatic cmd(input logic [39:0] w, input int n, input logic hit,
		input sfe_note_type e, input logic wp_mid);
		int nb;
		nb = 0;
		if (hit) notes.push_back(e);
		u_sfe_host.xfer(w, n);
		for (int i = 0; i < 60; i++) begin
			@(posedge clock);
			#2;
			if (i == 8 && wp_mid) wp_n = 1'b0;
			if (busy === 1'b1) begin
				nb++;
				if (wp_mid) cmp({7'h00, protect_active}, 8'h00, "early wp");
			end
		end
		cmp(8'(nb), hit ? 8'h14 : 8'h00, "busy length");
		if (wp_mid) cmp({7'h00, protect_active}, 8'h01, "wp late");
	endtask
	// Outputs are looked at mid-cycle, well clear of the launching edge
	always @(negedge clock) begin
		if (erase_strobe === 1'b1) begin
			if (notes.size() == 0) fail("erase without command");
			else begin
				mon_note = notes.pop_front();
				cmp({6'h00, erase_req.kind}, {6'h00, mon_note.k}, "kind");
				if (mon_note.k == sfe_pkg::SFE_KIND_BLOCK)
					cmp({1'b0, erase_req.block}, {1'b0, mon_note.v}, "block");
				else if (mon_note.k == sfe_pkg::SFE_KIND_SECTOR)
					cmp({4'h0, erase_req.sector}, {1'b0, mon_note.v}, "sector");
				if (mon_note.k != sfe_pkg::SFE_KIND_BLOCK)
					cmp(erase_sector_map, mon_note.m, "map");
				cmp(erase_fill, 8'hFF, "fill");
			end
		end
	end
	initial begin
		#1000000;
		fail("timeout");
		wrap_up();
	end
	initial begin
		logic [6:0] edges[5] = '{7'h00, 7'h01, 7'h0F, 7'h10, 7'h7F};
		logic [6:0] b;
		logic [39:0] w;
		sfe_note_type e;
		void'($urandom(11655));
		repeat (20) @(posedge clock);
		#2 rst = 1'b0;
		repeat (5) @(posedge clock);
		for (int i = 0; i < 12; i++) begin
			b = (i < 5) ? edges[i] : 7'($urandom);
			page_size_256 = i[0];
			e = '{sfe_pkg::SFE_KIND_BLOCK, b, 8'h00};
			cmd({8'h00, `SFE_OP_BLOCK_ERASE, place(b)}, 32, 1'b1, e, 1'b0);
			cmd({8'h00, `SFE_OP_SECTOR_ERASE, place(b)}, 32, 1'b1, sec_note(b), 1'b0);
		end
		$display("test address decode done");
		for (int i = 0; i < 4; i++) begin
			protect_map = 8'($urandom);
			lock_map = 8'($urandom);
			sw_protect = 1'($urandom);
			repeat (4) @(posedge clock);
			e = '{sfe_pkg::SFE_KIND_CHIP, 7'h00,
				~(lock_map | (sw_protect ? protect_map : 8'h00))};
			w = {`SFE_CE_BYTE0, `SFE_CE_BYTE1, `SFE_CE_BYTE2, `SFE_CE_BYTE3,
				8'($urandom)};
			// Without the trailing byte the sequence sits in the low 32 bits
			if (!i[0]) w = w >> 8;
			cmd(w, 32 + 8 * i[0], 1'b1, e, 1'b0);
		end
		$display("test chip erase done");
		cmd({8'h00, `SFE_CE_BYTE0, `SFE_CE_BYTE2, `SFE_CE_BYTE1, `SFE_CE_BYTE3},
			32, 1'b0, e, 1'b0);
		cmd({24'h000000, `SFE_OP_SECTOR_ERASE, 8'h00}, 16, 1'b0, e, 1'b0);
		$display("test refused commands done");
		sw_protect = 1'b0;
		repeat (4) @(posedge clock);
		e = '{sfe_pkg::SFE_KIND_CHIP, 7'h00, ~lock_map};
		cmd({8'h00, `SFE_CE_BYTE0, `SFE_CE_BYTE1, `SFE_CE_BYTE2, `SFE_CE_BYTE3},
			32, 1'b1, e, 1'b1);
		wp_n = 1'b1;
		$display("test deferred protect done");
		wrap_up();
	end
endmodule
